/* File: sdcc_pkg.sv */
`default_nettype none
package sdcc_pkg;

   // ***************************************************************
   // Clock and timing
   // ***************************************************************
   localparam int unsigned CLK_HZ          = 200_000_000;
   localparam int unsigned CLK_PERIOD_NS   = 5;
   localparam int unsigned LED_TICK_MS     = 250;
   localparam int unsigned LED_TICK_CYCLES = CLK_HZ / 1000 * LED_TICK_MS;
   localparam int unsigned SMOOTH_MIN_NS   = 50;
   localparam int unsigned SMOOTH_MAX_NS   = 1000;
   // Least step spacing rounds up, longest start spacing rounds down
   localparam logic [15:0] SMOOTH_MIN_CYC  = 16'((SMOOTH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [15:0] SMOOTH_MAX_CYC  = 16'(SMOOTH_MAX_NS / CLK_PERIOD_NS);
   localparam logic [1:0]  BOOT_WAIT       = 2'h2;

   // ***************************************************************
   // Resolution, pins and fault coding
   // ***************************************************************
   localparam logic [15:0] DEFAULT_STEPS   = 16'h0fa0;
   localparam int unsigned PIN_W           = 13;
   localparam int unsigned FAULT_W         = 5;
   localparam int unsigned F_OVERCURRENT   = 0;
   localparam int unsigned F_OVERVOLTAGE   = 1;
   localparam int unsigned F_INT_SUPPLY    = 2;
   localparam int unsigned F_TRACKING      = 3;
   localparam int unsigned F_ENC_PHASE     = 4;
   localparam logic [4:0]  LED_PAUSE_SLOTS = 5'h04;

   typedef enum logic [1:0] {
      SDCC_STEP_AND_SENSE = 2'b00,
      SDCC_FWD_REV        = 2'b01,
      SDCC_QUADRATURE     = 2'b10
   } sdcc_mode_t;

   // Latched power-up configuration
   typedef struct packed {
      logic done;
      logic rot_fwd;
      logic smooth_on;
      logic format_dual;
   } sdcc_cfg_t;

   // Whole state of the top module
   typedef struct packed {
      logic [1:0]         boot_cnt;
      sdcc_cfg_t          cfg;
      logic               closed;
      logic [15:0]        steps;
      logic [1:0]         cmd_prev;
      logic [1:0]         enc_prev;
      logic signed [15:0] backlog;
      logic [15:0]        interval;
      logic [15:0]        timer;
      logic               step_out;
      logic               dir_out;
      logic signed [31:0] cmd_pos;
      logic signed [31:0] enc_pos;
      logic signed [31:0] pos_err;
      logic [4:0]         faults;
      logic [31:0]        tick_cnt;
      logic               tick;
      logic [4:0]         slot;
      logic               green;
      logic               red;
   } sdcc_state_t;

   // Pattern index: bit set means switch off, first switch is bit 0
   function automatic logic [15:0] steps_of(input logic [3:0] idx);
      case (idx)
         4'h1:    steps_of = 16'h0320;
         4'h2:    steps_of = 16'h0640;
         4'h3:    steps_of = 16'h0c80;
         4'h4:    steps_of = 16'h1900;
         4'h5:    steps_of = 16'h3200;
         4'h6:    steps_of = 16'h6400;
         4'h7:    steps_of = 16'h1c20;
         4'h8:    steps_of = 16'h03e8;
         4'h9:    steps_of = 16'h07d0;
         4'ha:    steps_of = 16'h0fa0;
         4'hb:    steps_of = 16'h1388;
         4'hc:    steps_of = 16'h1f40;
         4'hd:    steps_of = 16'h2710;
         4'he:    steps_of = 16'h4e20;
         4'hf:    steps_of = 16'h9c40;
         default: steps_of = 16'h0000;
      endcase
   endfunction

   // Quadrature step: {moved, forward, illegal double change}
   function automatic logic [2:0] quad_of(input logic [1:0] prev, input logic [1:0] cur);
      logic both;
      logic one;
      both = (prev[1] != cur[1]) && (prev[0] != cur[0]);
      one  = (prev != cur) && !both;
      quad_of = {one, prev[1] ^ cur[0], both};
   endfunction

endpackage
`default_nettype wire

/* File: sdcc_sync2.sv */
`timescale 1ns/1ps
`default_nettype none
module sdcc_sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sdcc_sync_state_t;

   sdcc_sync_state_t s_q;
   sdcc_sync_state_t s_d;

   // Only the second stage is visible; the first may be metastable
   always_comb begin
      s_d.meta   = d_i;
      s_d.stable = s_q.meta;
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign q_o = s_q.stable;

endmodule
`default_nettype wire

/* File: sdcc_top.sv */
// Operation
// - Four switches pick one of sixteen resolutions
// - All switches on selects default or software resolution
// - Rotation switch on forward, off reverses sense
// - Direction, smoothing, format switches sampled at power-up
// - Smoothing switch on shapes steps through S-ramp
// - Format off step-and-sense, on forward/reverse pulses
// - Quadrature command format selectable by software only
// - Fault output reports the alarm state
// - Encoder A/B channels give position feedback
// - Not allowed: green steady, red dark
// - Normal running: green flashes
// - Overcurrent: one green, one red flash
// - Overvoltage: one green, two red flashes
// - Internal supply fault: one green, three red
// - Tracking error over limit: one green, four red
// - Encoder phase error: one green, five red
`timescale 1ns/1ps
`default_nettype none
module sdcc_top #(
   parameter int unsigned LED_TICK_CYCLES = sdcc_pkg::LED_TICK_CYCLES
) (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic [3:0]  microstep_select_switches_i,
   input  wire logic        initial_rotation_switch_i,
   input  wire logic        s_curve_smoothing_switch_i,
   input  wire logic        pulse_format_switch_i,
   input  wire logic        loop_mode_switch_i,
   input  wire logic        step_pulse_input_i,
   input  wire logic        sense_input_i,
   input  wire logic        drive_allow_input_i,
   input  wire logic        feedback_channel_first_i,
   input  wire logic        feedback_channel_second_i,
   input  wire logic        sw_quadrature_i,
   input  wire logic        sw_res_valid_i,
   input  wire logic [15:0] sw_resolution_i,
   input  wire logic [31:0] tracking_limit_i,
   input  wire logic        fault_overcurrent_i,
   input  wire logic        fault_overvoltage_i,
   input  wire logic        fault_int_supply_i,
   output logic [15:0]      steps_per_rev_o,
   output logic [1:0]       pulse_mode_o,
   output logic             motor_step_o,
   output logic             motor_dir_o,
   output logic             energise_o,
   output logic             closed_loop_o,
   output logic [31:0]      position_error_o,
   output logic             fault_output_o,
   output logic             led_green_o,
   output logic             led_red_o
);

   // ***************************************************************
   // Pin synchronisers
   // ***************************************************************
   logic [sdcc_pkg::PIN_W-1:0] pins_s;
   logic [3:0]                 ms_s;
   logic                       rot_s;
   logic                       smooth_s;
   logic                       fmt_s;
   logic                       loop_s;
   logic                       step_s;
   logic                       sense_s;
   logic                       allow_s;
   logic                       enc_a_s;
   logic                       enc_b_s;

   // Switches also cross here: a bank toggled mid-capture must not split
   sdcc_sync2 #(
      .WIDTH (sdcc_pkg::PIN_W)
   ) u_sync (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .d_i     ({loop_mode_switch_i, pulse_format_switch_i, s_curve_smoothing_switch_i,
                 initial_rotation_switch_i, microstep_select_switches_i,
                 feedback_channel_second_i, feedback_channel_first_i,
                 drive_allow_input_i, sense_input_i, step_pulse_input_i}),
      .q_o     (pins_s)
   );

   assign {loop_s, fmt_s, smooth_s, rot_s, ms_s, enc_b_s, enc_a_s, allow_s, sense_s, step_s} = pins_s;

   // ***************************************************************
   // State
   // ***************************************************************
   sdcc_pkg::sdcc_state_t s_q;
   sdcc_pkg::sdcc_state_t s_d;
   sdcc_pkg::sdcc_mode_t  mode;
   logic                  run;
   logic                  cmd_step;
   logic                  cmd_dir;
   logic                  mdir;
   logic [2:0]            cq;
   logic [2:0]            eq;
   logic                  out_step;
   logic                  out_dir;
   logic signed [15:0]    delta;
   logic [31:0]           err_abs;
   logic [2:0]            code;
   logic [4:0]            last_slot;
   logic [4:0]            slot_n;

   // Quadrature beats the switch; the switch itself stays frozen after boot
   assign mode = sw_quadrature_i ? sdcc_pkg::SDCC_QUADRATURE :
                 (s_q.cfg.format_dual ? sdcc_pkg::SDCC_FWD_REV : sdcc_pkg::SDCC_STEP_AND_SENSE);
   assign run  = s_q.cfg.done && allow_s && (s_q.faults == '0);

   // ***************************************************************
   // Next state
   // ***************************************************************
   always_comb begin
      s_d      = s_q;
      cmd_step = 1'b0;
      cmd_dir  = 1'b0;
      out_step = 1'b0;
      out_dir  = 1'b0;
      delta    = 16'sh0000;
      code     = 3'h0;
      cq       = sdcc_pkg::quad_of(s_q.cmd_prev, {step_s, sense_s});
      eq       = sdcc_pkg::quad_of(s_q.enc_prev, {enc_a_s, enc_b_s});
      s_d.step_out = 1'b0;

      // Capture once, after the synchronisers hold real switch levels
      if (!s_q.cfg.done) begin
         if (s_q.boot_cnt == sdcc_pkg::BOOT_WAIT) begin
            s_d.cfg.done        = 1'b1;
            s_d.cfg.rot_fwd     = rot_s;
            s_d.cfg.smooth_on   = smooth_s;
            s_d.cfg.format_dual = fmt_s;
         end else begin
            s_d.boot_cnt = s_q.boot_cnt + 2'h1;
         end
      end

      // Resolution and loop mode follow the switches live
      if (ms_s == 4'hf) begin
         s_d.steps = sw_res_valid_i ? sw_resolution_i : sdcc_pkg::DEFAULT_STEPS;
      end else begin
         s_d.steps = sdcc_pkg::steps_of(~ms_s);
      end
      s_d.closed   = !loop_s;
      s_d.cmd_prev = {step_s, sense_s};
      s_d.enc_prev = {enc_a_s, enc_b_s};

      // Command decode for the three formats
      case (mode)
         sdcc_pkg::SDCC_STEP_AND_SENSE: begin
            cmd_step = step_s && !s_q.cmd_prev[1];
            cmd_dir  = sense_s;
         end
         sdcc_pkg::SDCC_FWD_REV: begin
            // Coincident edges cancel rather than guess a direction
            cmd_step = (step_s && !s_q.cmd_prev[1]) != (sense_s && !s_q.cmd_prev[0]);
            cmd_dir  = step_s && !s_q.cmd_prev[1];
         end
         sdcc_pkg::SDCC_QUADRATURE: begin
            cmd_step = cq[2];
            cmd_dir  = cq[1];
         end
         default: begin
            cmd_step = 1'b0;
            cmd_dir  = 1'b0;
         end
      endcase
      cmd_step = cmd_step && run;
      mdir     = ~(cmd_dir ^ s_q.cfg.rot_fwd);

      // Step path, straight or through the ramp
      if (!run) begin
         s_d.backlog  = 16'sh0000;
         s_d.interval = sdcc_pkg::SMOOTH_MAX_CYC;
         s_d.timer    = 16'h0000;
      end else if (!s_q.cfg.smooth_on) begin
         out_step = cmd_step;
         out_dir  = mdir;
      end else begin
         // Spacing shrinks while work is pending and resets when idle
         if (cmd_step) begin
            delta = mdir ? 16'sh0001 : -16'sh0001;
         end
         if (s_q.timer != 16'h0000) begin
            s_d.timer = s_q.timer - 16'h0001;
         end else if (s_q.backlog != 16'sh0000) begin
            out_step  = 1'b1;
            out_dir   = !s_q.backlog[15];
            delta     = delta - (out_dir ? 16'sh0001 : -16'sh0001);
            s_d.timer = s_q.interval;
            if (s_q.interval > sdcc_pkg::SMOOTH_MIN_CYC) begin
               s_d.interval = s_q.interval - 16'h0001;
            end
         end else begin
            s_d.interval = sdcc_pkg::SMOOTH_MAX_CYC;
         end
         s_d.backlog = s_q.backlog + delta;
      end
      s_d.step_out = out_step;
      if (out_step) begin
         s_d.dir_out = out_dir;
         s_d.cmd_pos = s_q.cmd_pos + (out_dir ? 32'sh1 : -32'sh1);
      end

      // Encoder count and tracking error; open loop keeps them aligned
      // Changes seen before capture come from the zeroed synchroniser, not the shaft
      if (s_q.closed) begin
         if (eq[2] && s_q.cfg.done) begin
            s_d.enc_pos = s_q.enc_pos + (eq[1] ? 32'sh1 : -32'sh1);
         end
         s_d.pos_err = s_q.cmd_pos - s_q.enc_pos;
      end else begin
         s_d.enc_pos = s_q.cmd_pos;
         s_d.pos_err = 32'sh0;
      end
      err_abs = s_q.pos_err[31] ? 32'(-s_q.pos_err) : 32'(s_q.pos_err);

      // Faults stay set until reset
      if (s_q.cfg.done) begin
         s_d.faults[sdcc_pkg::F_OVERCURRENT] = s_q.faults[sdcc_pkg::F_OVERCURRENT] || fault_overcurrent_i;
         s_d.faults[sdcc_pkg::F_OVERVOLTAGE] = s_q.faults[sdcc_pkg::F_OVERVOLTAGE] || fault_overvoltage_i;
         s_d.faults[sdcc_pkg::F_INT_SUPPLY]  = s_q.faults[sdcc_pkg::F_INT_SUPPLY] || fault_int_supply_i;
         s_d.faults[sdcc_pkg::F_TRACKING]    = s_q.faults[sdcc_pkg::F_TRACKING] ||
                                               (s_q.closed && (err_abs > tracking_limit_i));
         s_d.faults[sdcc_pkg::F_ENC_PHASE]   = s_q.faults[sdcc_pkg::F_ENC_PHASE] ||
                                               (s_q.closed && eq[0]);
      end

      // Indicator tick divider
      s_d.tick = 1'b0;
      if (s_q.tick_cnt >= 32'(LED_TICK_CYCLES - 1)) begin
         s_d.tick_cnt = 32'h0;
         s_d.tick     = 1'b1;
      end else begin
         s_d.tick_cnt = s_q.tick_cnt + 32'h1;
      end

      // Lowest numbered fault wins the indicator
      for (int i = sdcc_pkg::FAULT_W - 1; i >= 0; i--) begin
         if (s_q.faults[i]) begin
            code = 3'(i + 1);
         end
      end
      last_slot = 5'({code, 1'b1}) + sdcc_pkg::LED_PAUSE_SLOTS;
      slot_n    = (s_q.slot >= last_slot) ? 5'h00 : s_q.slot + 5'h01;

      if (s_q.tick) begin
         if (code != 3'h0) begin
            // Green slot, then code red flashes on even slots, then a pause
            s_d.slot  = slot_n;
            s_d.green = (slot_n == 5'h00);
            s_d.red   = (slot_n >= 5'h02) && (slot_n <= 5'({code, 1'b0})) && !slot_n[0];
         end else if (!allow_s) begin
            s_d.slot  = 5'h00;
            s_d.green = 1'b1;
            s_d.red   = 1'b0;
         end else begin
            s_d.slot  = 5'h00;
            s_d.green = !s_q.green;
            s_d.red   = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   assign steps_per_rev_o  = s_q.steps;
   assign pulse_mode_o     = mode;
   assign motor_step_o     = s_q.step_out;
   assign motor_dir_o      = s_q.dir_out;
   assign energise_o       = run;
   assign closed_loop_o    = s_q.closed;
   assign position_error_o = s_q.pos_err;
   assign fault_output_o   = (s_q.faults != '0);
   assign led_green_o      = s_q.green;
   assign led_red_o        = s_q.red;

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   a_res_table: assert property ((ms_s == 4'he) |=> (steps_per_rev_o == 16'h0320))
      else $error("resolution 800 not decoded");
   a_res_default: assert property ((ms_s == 4'hf) && !sw_res_valid_i |=> (steps_per_rev_o == 16'h0fa0))
      else $error("default resolution not chosen");
   a_cfg_frozen: assert property (s_q.cfg.done |=> $stable(s_q.cfg))
      else $error("power-up configuration changed");
   a_dir_sense: assert property (run && !s_q.cfg.smooth_on && (mode == sdcc_pkg::SDCC_STEP_AND_SENSE)
                                 && step_s && !s_q.cmd_prev[1]
                                 |=> motor_step_o && (motor_dir_o == ~($past(sense_s) ^ s_q.cfg.rot_fwd)))
      else $error("step-and-sense step lost or wrong sense");
   a_smooth_gap: assert property (motor_step_o && s_q.cfg.smooth_on |=> !motor_step_o [*8])
      else $error("smoothed steps too close");
   a_quad_step: assert property (run && !s_q.cfg.smooth_on && (mode == sdcc_pkg::SDCC_QUADRATURE) && cq[2]
                                 |=> motor_step_o)
      else $error("quadrature step lost");
   a_no_run: assert property (!energise_o |=> !motor_step_o)
      else $error("step while not allowed");
   a_fault_out: assert property (s_q.cfg.done && fault_overcurrent_i |=> fault_output_o ##1 fault_output_o)
      else $error("fault output not held");
   a_open_loop: assert property (!closed_loop_o |=> (position_error_o == 32'h0))
      else $error("error reported in open loop");
   a_track_lim: assert property (s_q.cfg.done && s_q.closed && (err_abs > tracking_limit_i)
                                 |=> s_q.faults[sdcc_pkg::F_TRACKING])
      else $error("tracking fault not raised");
   a_enc_phase: assert property (s_q.cfg.done && s_q.closed && eq[0] |=> s_q.faults[sdcc_pkg::F_ENC_PHASE])
      else $error("encoder phase fault not raised");
   a_led_idle: assert property (s_q.tick && (s_q.faults == '0) && !allow_s |=> led_green_o && !led_red_o)
      else $error("idle indicator wrong");
   a_led_flash: assert property (s_q.tick && (s_q.faults == '0) && allow_s |=> (led_green_o != $past(led_green_o)))
      else $error("green does not flash");
   a_red_fault: assert property (led_red_o |-> fault_output_o)
      else $error("red lit without fault");

   c_smooth_run: cover property (motor_step_o && s_q.cfg.smooth_on);
   c_dual_step: cover property (motor_step_o && (mode == sdcc_pkg::SDCC_FWD_REV));
   c_red_flash: cover property (led_red_o && (s_q.slot == 5'h04));
   c_track_flt: cover property (s_q.faults[sdcc_pkg::F_TRACKING]);

endmodule
`default_nettype wire

/* File: sdcc_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ***********************************
// Upper controller issuing step commands
// ***********************************
module sdcc_ctrl_model (
   input  wire logic clk_i,
   output logic      step_o,
   output logic      sense_o,
   output logic      allow_o
);
   // Pins idle low and only move on falling edges
   initial begin
      {step_o, sense_o, allow_o} = 3'h0;
   end
   // Four clocks a level, one more than the drive needs to capture it
   task automatic hold();
      repeat (4) @(negedge clk_i);
   endtask
   task automatic set_allow(input logic a);
      allow_o = a;
      hold();
   endtask
   // Command pins back to idle, used while the drive sits in reset
   task automatic park();
      {step_o, sense_o} = 2'b00;
   endtask
   // Issue one command step in the chosen format
   task automatic send(input sdcc_pkg::sdcc_mode_t m, input logic fwd);
      logic [1:0] q;
      q = {step_o, sense_o};
      if (m == sdcc_pkg::SDCC_STEP_AND_SENSE) begin
         sense_o = fwd;
         hold();
         q = {1'b1, fwd};
      end
      else if (m == sdcc_pkg::SDCC_FWD_REV) q = {fwd, ~fwd};
      else q = fwd ? {q[0], ~q[1]} : {~q[0], q[1]};
      {step_o, sense_o} = q;
      hold();
      // Quadrature keeps its level; step returns low, sense holds its level only in step-and-sense
      if (m != sdcc_pkg::SDCC_QUADRATURE) begin
         {step_o, sense_o} = {1'b0, (m == sdcc_pkg::SDCC_STEP_AND_SENSE) & sense_o};
         hold();
      end
   endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ***********************************
// Drive command and status bench
// ***********************************
module tb_top;
   logic        clk_i, rst_n_i, rot, smth, fmt, loop_sw, fb1, fb2, swq, rv, oc, ov, fis;
   logic        stp, sns, alw, mstep, mdir, ener, closed, fault, grn, red, g_q, r_q, ldir, d;
   logic [3:0]  sw;
   logic [15:0] sres, spr;
   logic [1:0]  pm;
   logic [31:0] lim, perr, s;
   int          err_total, n_tests, n_steps, reds, gap, min_gap, i, k;
   logic [15:0] res_tab [16] = '{16'h0fa0, 16'h0320, 16'h0640, 16'h0c80, 16'h1900, 16'h3200, 16'h6400,
      16'h1c20, 16'h03e8, 16'h07d0, 16'h0fa0, 16'h1388, 16'h1f40, 16'h2710, 16'h4e20, 16'h9c40};
   sdcc_ctrl_model u_ctl (.clk_i(clk_i), .step_o(stp), .sense_o(sns), .allow_o(alw));
   // Short LED tick keeps the blink codes inside a few hundred cycles
   sdcc_top #(.LED_TICK_CYCLES(8)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .microstep_select_switches_i(sw),
      .initial_rotation_switch_i(rot), .s_curve_smoothing_switch_i(smth), .pulse_format_switch_i(fmt),
      .loop_mode_switch_i(loop_sw), .step_pulse_input_i(stp), .sense_input_i(sns), .drive_allow_input_i(alw),
      .feedback_channel_first_i(fb1), .feedback_channel_second_i(fb2), .sw_quadrature_i(swq),
      .sw_res_valid_i(rv), .sw_resolution_i(sres), .tracking_limit_i(lim), .fault_overcurrent_i(oc),
      .fault_overvoltage_i(ov), .fault_int_supply_i(fis), .steps_per_rev_o(spr), .pulse_mode_o(pm),
      .motor_step_o(mstep), .motor_dir_o(mdir), .energise_o(ener), .closed_loop_o(closed),
      .position_error_o(perr), .fault_output_o(fault), .led_green_o(grn), .led_red_o(red));
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   // Step count, step spacing and LED edges, sampled before the design updates
   always @(posedge clk_i) begin
      gap++;
      if (red && !r_q) reds++;
      {g_q, r_q} = {grn, red};
      if (mstep === 1'b1) begin
         n_steps++;
         ldir = mdir;
         if (gap < min_gap) min_gap = gap;
         gap = 0;
      end
   end
   function automatic logic [31:0] rnd();
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Bounded waits; running out counts as a mismatch and ends the run
   task automatic wait_for(input bit green, input int n);
      int j;
      for (j = 0; j < 1000; j++) begin
         @(negedge clk_i);
         if (green ? (grn && !g_q) : (n_steps >= n)) return;
      end
      err_total++;
      report_and_stop();
   endtask
   // Power-up: switches settle during the 16-cycle reset
   task automatic boot(input logic r, input logic sm, input logic f);
      @(negedge clk_i);
      {rot, smth, fmt, fb1, fb2, swq, oc, ov, fis} = {r, sm, f, 6'h00};
      u_ctl.park();
      rst_n_i = 1'b0;
      repeat (16) @(negedge clk_i);
      rst_n_i = 1'b1;
      repeat (8) @(negedge clk_i);
   endtask
   task automatic step_chk(input sdcc_pkg::sdcc_mode_t m, input logic f, input logic e);
      k = n_steps + 1;
      u_ctl.send(m, f);
      check(n_steps, k);
      check(ldir, e);
   endtask
   initial begin
      {rst_n_i, sw, loop_sw, rv, sres, lim, n_steps, gap, err_total, n_tests} = '0;
      {s, min_gap} = {32'h35a43537, 32'h0000ffff};
      boot(1'b1, 1'b0, 1'b0);
      // Every switch pattern, then the software resolution when all are on
      for (i = 0; i < 16; i++) begin
         sw = 4'(i);
         repeat (6) @(negedge clk_i);
         check(spr, res_tab[~sw]);
      end
      {rv, sres} = {1'b1, 16'(rnd())};
      repeat (6) @(negedge clk_i);
      check(spr, sres);
      $display("test resolution done");
      lim = 32'h0000ffff;
      u_ctl.set_allow(1'b1);
      check(ener, 1'b1);
      check(pm, sdcc_pkg::SDCC_STEP_AND_SENSE);
      for (i = 0; i < 8; i++) begin
         d = 1'(rnd());
         step_chk(sdcc_pkg::SDCC_STEP_AND_SENSE, d, d);
      end
      rot = 1'b0;
      step_chk(sdcc_pkg::SDCC_STEP_AND_SENSE, 1'b1, 1'b1);
      u_ctl.set_allow(1'b0);
      k = n_steps;
      u_ctl.send(sdcc_pkg::SDCC_STEP_AND_SENSE, 1'b1);
      check(n_steps, k);
      for (i = 0; i < 4; i++) begin
         repeat (10) @(negedge clk_i);
         check({grn, red}, 2'b10);
      end
      u_ctl.set_allow(1'b1);
      wait_for(1'b1, 0);
      wait_for(1'b1, 0);
      loop_sw = 1'b1;
      step_chk(sdcc_pkg::SDCC_STEP_AND_SENSE, 1'b1, 1'b1);
      check(closed, 1'b0);
      check(perr, 32'h0);
      loop_sw = 1'b0;
      step_chk(sdcc_pkg::SDCC_STEP_AND_SENSE, 1'b1, 1'b1);
      check(closed, 1'b1);
      check(perr, 32'h1);
      fb2 = 1'b1;
      repeat (8) @(negedge clk_i);
      check(perr, 32'h0);
      $display("test step and sense done");
      boot(1'b0, 1'b0, 1'b1);
      check(pm, sdcc_pkg::SDCC_FWD_REV);
      step_chk(sdcc_pkg::SDCC_FWD_REV, 1'b1, 1'b0);
      step_chk(sdcc_pkg::SDCC_FWD_REV, 1'b0, 1'b1);
      swq = 1'b1;
      // Mode output is combinational: let it settle before looking
      @(negedge clk_i);
      check(pm, sdcc_pkg::SDCC_QUADRATURE);
      // Rotation switch off reverses the forward quadrature sense
      step_chk(sdcc_pkg::SDCC_QUADRATURE, 1'b1, 1'b0);
      d = 1'b0;
      for (i = 0; i < 4; i++) step_chk(sdcc_pkg::SDCC_QUADRATURE, 1'b1, d);
      for (i = 0; i < 4; i++) step_chk(sdcc_pkg::SDCC_QUADRATURE, 1'b0, ~d);
      $display("test pulse formats done");
      boot(1'b1, 1'b1, 1'b0);
      {min_gap, k} = {32'h0000ffff, n_steps + 3};
      for (i = 0; i < 3; i++) u_ctl.send(sdcc_pkg::SDCC_STEP_AND_SENSE, 1'b1);
      wait_for(1'b0, k);
      check(min_gap > 12, 1'b1);
      $display("test smoothing done");
      // One boot per fault, since fault bits hold until reset
      for (i = 1; i < 6; i++) begin
         lim = (i == 4) ? 32'h0 : 32'h0000ffff;
         boot(1'b1, 1'b0, 1'b0);
         case (i)
            1: oc = 1'b1;
            2: ov = 1'b1;
            3: fis = 1'b1;
            4: u_ctl.send(sdcc_pkg::SDCC_STEP_AND_SENSE, 1'b1);
            default: {fb1, fb2} = 2'b11;
         endcase
         repeat (8) @(negedge clk_i);
         check({fault, ener}, 2'b10);
         wait_for(1'b1, 0);
         reds = 0;
         wait_for(1'b1, 0);
         check(reds, i);
      end
      $display("test fault codes done");
      report_and_stop();
   end
endmodule
`default_nettype wire
